// *** design/fps_pkg.sv ***
// Constants and state types of the program/erase sequencer.
// Assumes a 100 MHz system clock and a host on a serial flash bus.
package fps_pkg;
    // ********************************
    // Instruction codes
    // ********************************
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_QPROG = 8'h32;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hD8;
    localparam logic [7:0] OP_CE1 = 8'hC7;
    localparam logic [7:0] OP_CE2 = 8'h60;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    // ********************************
    // Frame layout and array geometry
    // ********************************
    localparam logic [2:0] BC_OPC = 3'h0;
    localparam logic [2:0] BC_ADR3 = 3'h3;
    localparam logic [2:0] BC_DATA = 3'h4;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam logic [7:0] PAGE_LAST = 8'hFF;
    localparam logic [23:0] MEM_TOP = 24'h3FFFFF;
    localparam logic [23:0] SPAN_SE = 24'h000FFF;
    localparam logic [23:0] SPAN_B32 = 24'h007FFF;
    localparam logic [23:0] SPAN_B64 = 24'h00FFFF;
    localparam logic [23:0] PROT_SEC_BASE = 24'h001000;
    localparam logic [23:0] PROT_BLK_BASE = 24'h010000;
    localparam int ST_BUSY_POS = 0;
    localparam int ST_LATCH_POS = 1;
    // ********************************
    // Self-timed cycle lengths
    // ********************************
    localparam int CLK_MHZ = 100;
    localparam int T_PP_US = 700;
    localparam int T_SE_US = 45000;
    localparam int T_BE32_US = 120000;
    localparam int T_BE64_US = 150000;
    localparam int T_CE_US = 10000000;
    localparam int unsigned PP_CYC_DEF = T_PP_US * CLK_MHZ;
    localparam int unsigned SE_CYC_DEF = T_SE_US * CLK_MHZ;
    localparam int unsigned B32_CYC_DEF = T_BE32_US * CLK_MHZ;
    localparam int unsigned B64_CYC_DEF = T_BE64_US * CLK_MHZ;
    localparam int unsigned CE_CYC_DEF = T_CE_US * CLK_MHZ;
    // ********************************
    // State types
    // ********************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_COPY = 2'b01, ST_WAIT = 2'b10
    } fps_state_t;
    typedef enum logic [1:0] {
        ER_SECTOR = 2'b00, ER_BLK32 = 2'b01, ER_BLK64 = 2'b10, ER_CHIP = 2'b11
    } fps_erase_t;
    typedef struct packed {
        logic [2:0] bcnt;
        logic [2:0] byc;
        logic [7:0] sh;
        logic [7:0] opc;
        logic [23:0] addr;
        logic [7:0] wp;
        logic [8:0] nb;
        logic [255:0] mask;
        logic [7:0] ssh;
        logic dout, rd, ftog, bs1, bs2, ws1, ws2;
    } fps_lnk_t;
    typedef struct packed {
        logic cs1, cs2, cs3, cs_lvl, ft1, ft2, ft3, ft_seen;
        logic wlat, busy;
        fps_state_t st;
        logic [31:0] tmr;
        logic [8:0] idx;
        logic [15:0] page;
        logic we;
        logic [23:0] wa;
        logic [7:0] wd;
        logic ego;
        fps_erase_t ek;
        logic [23:0] ea;
    } fps_sys_t;
    localparam fps_lnk_t LNK_RST = '0;
    // Chip select stages rest at its idle level, so no false rise follows reset
    localparam fps_sys_t SYS_RST = '{cs1: 1'b1, cs2: 1'b1, cs3: 1'b1, cs_lvl: 1'b1, st: ST_IDLE, ek: ER_SECTOR,
                                     default: '0};
endpackage : fps_pkg

// *** design/fps_sequencer.sv ***
// Program/erase instruction decoder and self-timed sequencer.
// Assumes the protect bits, quad enable and locks come from logic on
// clk_sys_i, and that the array behind the arr_ and erase_ ports does
// the cell work (program only clears bits, erase sets all ones).
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Page program: 02h, 24-bit address, then data bytes on lane 0.
// - One or more data bytes accepted per page program.
// - Program refused unless the write enable latch is set.
// - Low address byte picks the byte; data wraps inside the page.
// - Over 256 bytes: wrap and overwrite, last 256 kept.
// - Bytes of the page not sent are left untouched.
// - Program dropped unless chip select rises on a byte boundary.
// - Chip select rise after valid program starts the timed cycle.
// - Busy reads 1 during any cycle; status read stays available.
// - Write enable latch cleared when any cycle ends.
// - Protected page, sector or block is not programmed or erased.
// - Quad program 32h needs quad enable and the write latch.
// - Quad program otherwise behaves as page program, with data on all four lanes.
// - 20h erases the addressed 4K sector, sector erase time.
// - 52h erases the addressed 32K block, short block time.
// - D8h erases the addressed 64K block, long block time.
// - Erase needs chip select rise right after the last address byte.
// - C7h or 60h erases all; rise right after the opcode.
// - Chip erase refused if any region is protected or locked.
module fps_sequencer #(
    parameter int unsigned PP_CYC = fps_pkg::PP_CYC_DEF,
    parameter int unsigned SE_CYC = fps_pkg::SE_CYC_DEF,
    parameter int unsigned B32_CYC = fps_pkg::B32_CYC_DEF,
    parameter int unsigned B64_CYC = fps_pkg::B64_CYC_DEF,
    parameter int unsigned CE_CYC = fps_pkg::CE_CYC_DEF
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic [3:0] io_i,
    output logic dout_o,
    output logic dout_oe_o,
    input wire logic quad_enable_bit_i,
    input wire logic protect_complement_i,
    input wire logic sector_granularity_select_i,
    input wire logic top_bottom_select_i,
    input wire logic [2:0] protect_range_i,
    input wire logic [63:0] block_lock_i,
    output logic busy_o,
    output logic write_enable_latch_o,
    output logic arr_we_o,
    output logic [23:0] arr_addr_o,
    output logic [7:0] arr_wdata_o,
    output logic erase_go_o,
    output fps_pkg::fps_erase_t erase_kind_o,
    output logic [23:0] erase_addr_o
);
    import fps_pkg::*;

    // ********************************
    // Protection decode
    // ********************************
    function automatic logic prot_hit(input logic [23:0] a);
        logic [23:0] sz;
        logic [2:0] sft;
        logic hit;
        sft = protect_range_i - 3'h1;
        hit = 1'b0;
        if (protect_range_i == 3'h7) begin
            hit = 1'b1;
        end else if (protect_range_i != 3'h0) begin
            if (sector_granularity_select_i) begin
                sz = PROT_SEC_BASE << ((sft > 3'h3) ? 3'h3 : sft);
            end else begin
                sz = PROT_BLK_BASE << sft;
            end
            hit = top_bottom_select_i ? (a < sz) : (a > MEM_TOP - sz);
        end
        return hit ^ protect_complement_i;
    endfunction : prot_hit

    // Regions grow from one end of the array, so testing both ends of a
    // range is enough to tell whether any part of it is protected.
    function automatic logic range_prot(input logic [23:0] lo, input logic [23:0] hi);
        return prot_hit(lo) | prot_hit(hi) | block_lock_i[lo[21:16]] | block_lock_i[hi[21:16]];
    endfunction : range_prot

    // ********************************
    // Link side, on the serial clock
    // ********************************
    fps_lnk_t lr;
    fps_lnk_t ln;
    fps_sys_t sr;
    fps_sys_t sn;
    logic [7:0] pbuf [256];
    logic frame_run;
    logic first;
    logic quad;
    logic pwe;
    logic [7:0] sh_n;
    logic [3:0] bsum;
    logic [2:0] byc0;
    logic [7:0] stat;
    wire frame_rst_n = resetn_i & ~cs_n_i;

    // Cleared while chip select is high, so the first edge of a frame
    // is recognised without counting on any edge outside the frame.
    always_ff @(posedge sclk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            frame_run <= 1'b0;
        end else begin
            frame_run <= 1'b1;
        end
    end

    always_comb begin
        ln = lr;
        pwe = 1'b0;
        first = ~frame_run;
        quad = (lr.opc == OP_QPROG) && (lr.byc == BC_DATA) && !first;
        sh_n = quad ? {lr.sh[3:0], io_i} : {lr.sh[6:0], io_i[0]};
        bsum = {1'b0, first ? 3'h0 : lr.bcnt} + (quad ? 4'h4 : 4'h1);
        byc0 = first ? BC_OPC : lr.byc;
        stat = '0;
        stat[ST_BUSY_POS] = lr.bs2;
        stat[ST_LATCH_POS] = lr.ws2;
        ln.sh = sh_n;
        ln.bcnt = bsum[2:0];
        ln.byc = byc0;
        ln.bs1 = busy_o;
        ln.bs2 = lr.bs1;
        ln.ws1 = write_enable_latch_o;
        ln.ws2 = lr.ws1;
        if (first) begin
            ln.ftog = ~lr.ftog;
            ln.rd = 1'b0;
        end
        if (ln.rd) begin
            ln.dout = lr.ssh[7];
            ln.ssh = {lr.ssh[6:0], 1'b0};
        end
        if (bsum[3]) begin
            ln.byc = (byc0 == BC_DATA) ? byc0 : byc0 + 3'h1;
            if (byc0 == BC_OPC) begin
                ln.opc = sh_n;
                ln.nb = '0;
                ln.rd = (sh_n == OP_RDSR);
                // Held while busy: the page being copied must not move
                if (!lr.bs2) begin
                    ln.mask = '0;
                end
            end else if (byc0 <= BC_ADR3) begin
                ln.addr = {lr.addr[15:0], sh_n};
                ln.wp = sh_n;
            end else begin
                ln.nb = (lr.nb == PAGE_BYTES) ? lr.nb : lr.nb + 9'h001;
                if ((lr.opc == OP_PROG || lr.opc == OP_QPROG) && !lr.bs2) begin
                    ln.mask[lr.wp] = 1'b1;
                    ln.wp = lr.wp + 8'h01;
                    pwe = 1'b1;
                end
            end
            if (ln.rd) begin
                ln.dout = stat[7];
                ln.ssh = {stat[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lr <= LNK_RST;
        end else begin
            lr <= ln;
        end
    end

    // Later bytes at the same offset overwrite earlier ones
    always_ff @(posedge sclk_i) begin
        if (pwe) begin
            pbuf[lr.wp] <= sh_n;
        end
    end

    assign dout_o = lr.dout;
    // rd may still hold the last frame's value until the first edge of a new one
    assign dout_oe_o = lr.rd & frame_run & ~cs_n_i;

    // ********************************
    // Sequencer, on the system clock
    // ********************************
    // Frame fields are read only after chip select has risen and passed
    // the synchroniser; the serial clock is then quiet, so they are stable.
    logic rise;
    logic fresh;
    logic al;
    logic [23:0] span;
    logic [23:0] base;
    logic [31:0] ecyc;
    fps_erase_t ek;

    always_comb begin
        sn = sr;
        sn.we = 1'b0;
        sn.ego = 1'b0;
        sn.cs1 = cs_n_i;
        sn.cs2 = sr.cs1;
        sn.cs3 = sr.cs2;
        sn.ft1 = lr.ftog;
        sn.ft2 = sr.ft1;
        sn.ft3 = sr.ft2;
        if (sr.cs2 == sr.cs3) begin
            sn.cs_lvl = sr.cs3;
        end
        rise = (sr.cs2 == sr.cs3) && sr.cs3 && !sr.cs_lvl;
        fresh = (sr.ft2 == sr.ft3) && (sr.ft3 != sr.ft_seen);
        al = (lr.bcnt == 3'h0);
        span = SPAN_SE;
        ek = ER_SECTOR;
        ecyc = 32'(SE_CYC);
        if (lr.opc == OP_BE32) begin
            span = SPAN_B32;
            ek = ER_BLK32;
            ecyc = 32'(B32_CYC);
        end else if (lr.opc == OP_BE64) begin
            span = SPAN_B64;
            ek = ER_BLK64;
            ecyc = 32'(B64_CYC);
        end
        base = lr.addr & ~span;
        if (rise) begin
            sn.ft_seen = sr.ft3;
        end
        unique case (sr.st)
            ST_IDLE: begin
                // Anything that fails a check falls through untouched
                if (rise && fresh && al) begin
                    case (lr.opc)
                        OP_WREN: begin
                            if (lr.byc == 3'h1) begin
                                sn.wlat = 1'b1;
                            end
                        end
                        OP_WRDI: begin
                            if (lr.byc == 3'h1) begin
                                sn.wlat = 1'b0;
                            end
                        end
                        OP_PROG, OP_QPROG: begin
                            if (lr.byc == BC_DATA && lr.nb != 9'h000 && sr.wlat
                                && (lr.opc == OP_PROG || quad_enable_bit_i)
                                && !range_prot({lr.addr[23:8], 8'h00}, {lr.addr[23:8], PAGE_LAST})) begin
                                sn.busy = 1'b1;
                                sn.st = ST_COPY;
                                sn.idx = '0;
                                sn.page = lr.addr[23:8];
                            end
                        end
                        OP_SE, OP_BE32, OP_BE64: begin
                            if (lr.byc == BC_DATA && lr.nb == 9'h000 && sr.wlat
                                && !range_prot(base, base | span)) begin
                                sn.busy = 1'b1;
                                sn.st = ST_WAIT;
                                sn.tmr = ecyc;
                                sn.ego = 1'b1;
                                sn.ek = ek;
                                sn.ea = base;
                            end
                        end
                        OP_CE1, OP_CE2: begin
                            if (lr.byc == 3'h1 && sr.wlat && block_lock_i == 64'h0
                                && !range_prot(24'h000000, MEM_TOP)) begin
                                sn.busy = 1'b1;
                                sn.st = ST_WAIT;
                                sn.tmr = 32'(CE_CYC);
                                sn.ego = 1'b1;
                                sn.ek = ER_CHIP;
                                sn.ea = 24'h000000;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_COPY: begin
                // One pass over the page; only the bytes that arrived are written
                sn.we = lr.mask[sr.idx[7:0]];
                sn.wa = {sr.page, sr.idx[7:0]};
                sn.wd = pbuf[sr.idx[7:0]];
                sn.idx = sr.idx + 9'h001;
                if (sr.idx[7:0] == PAGE_LAST) begin
                    sn.st = ST_WAIT;
                    sn.tmr = 32'(PP_CYC);
                end
            end
            ST_WAIT: begin
                if (sr.tmr <= 32'h1) begin
                    sn.st = ST_IDLE;
                    sn.busy = 1'b0;
                    sn.wlat = 1'b0;
                end else begin
                    sn.tmr = sr.tmr - 32'h1;
                end
            end
            default: begin
                sn.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sr <= SYS_RST;
        end else begin
            sr <= sn;
        end
    end

    assign busy_o = sr.busy;
    assign write_enable_latch_o = sr.wlat;
    assign arr_we_o = sr.we;
    assign arr_addr_o = sr.wa;
    assign arr_wdata_o = sr.wd;
    assign erase_go_o = sr.ego;
    assign erase_kind_o = sr.ek;
    assign erase_addr_o = sr.ea;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    property p_latch_gate;
        $rose(sr.busy) |-> $past(sr.wlat);
    endproperty
    a_latch_gate: assert property (p_latch_gate) else $error("cycle started without latch");
    property p_latch_clr;
        $fell(sr.busy) |-> !sr.wlat && sr.st == ST_IDLE;
    endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch not cleared at end");
    property p_quad;
        $rose(sr.busy) && $past(lr.opc) == OP_QPROG |-> $past(quad_enable_bit_i);
    endproperty
    a_quad: assert property (p_quad) else $error("quad program without quad enable");
    property p_copy;
        sr.st == ST_COPY && sr.idx == 9'h000 |-> ##255 sr.st == ST_COPY ##1 sr.st == ST_WAIT;
    endproperty
    a_copy: assert property (p_copy) else $error("page pass not 256 cycles");
    property p_page;
        sr.we |-> sr.wa[23:8] == sr.page;
    endproperty
    a_page: assert property (p_page) else $error("write left the page");
    property p_mask;
        sr.we |-> lr.mask[sr.wa[7:0]];
    endproperty
    a_mask: assert property (p_mask) else $error("unsent byte written");
    property p_er_busy;
        sr.ego |-> sr.busy ##1 sr.busy;
    endproperty
    a_er_busy: assert property (p_er_busy) else $error("erase without busy");
    property p_prot;
        sr.ego && sr.ek != ER_CHIP |-> !prot_hit(sr.ea);
    endproperty
    a_prot: assert property (p_prot) else $error("protected region erased");
    property p_chip;
        sr.ego && sr.ek == ER_CHIP |-> block_lock_i == 64'h0;
    endproperty
    a_chip: assert property (p_chip) else $error("chip erase with locks");
    property p_done;
        sr.st == ST_WAIT && sr.tmr == 32'h1 |=> !sr.busy && sr.st == ST_IDLE;
    endproperty
    a_done: assert property (p_done) else $error("cycle end missed");

    c_prog: cover property ($rose(sr.busy) && $past(lr.opc) == OP_PROG);
    c_qprog: cover property ($rose(sr.busy) && $past(lr.opc) == OP_QPROG);
    c_wrap: cover property ($rose(sr.busy) && lr.nb == PAGE_BYTES);
    c_chip: cover property (sr.ego && sr.ek == ER_CHIP);
endmodule : fps_sequencer
`default_nettype wire

// *** sim/flash_program_erase_sequencer_tb_top.sv ***
// Self-checking bench of the program/erase sequencer against an associative-array model.
// Assumes fps_host_model on the link side and short timed-cycle parameters.
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_sequencer_tb_top;
    import fps_pkg::*;
    localparam logic [7:0] E_OP [5] = '{OP_SE, OP_BE32, OP_BE64, OP_CE1, OP_CE2};
    localparam fps_erase_t E_KIND [5] = '{ER_SECTOR, ER_BLK32, ER_BLK64, ER_CHIP, ER_CHIP};
    localparam logic [23:0] E_SPAN [5] = '{SPAN_SE, SPAN_B32, SPAN_B64, MEM_TOP, MEM_TOP};
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic sclk, cs_n, dout, dout_oe, busy, wlat, arr_we, erase_go;
    logic [3:0] io;
    logic quad_en = 1'b0, prot_inv = 1'b0, prot_4k = 1'b0, prot_low = 1'b0;
    logic [2:0] bp = 3'h0;
    logic [63:0] lock = 64'h0;
    logic [23:0] arr_addr, erase_addr, er_addr, adr;
    logic [7:0] arr_wdata;
    fps_erase_t erase_kind, er_kind;
    logic [7:0] act_mem [int];
    int fails = 0, check_count = 0, n_er = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    fps_host_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(io), .dout_i(dout), .dout_oe_i(dout_oe));
    fps_sequencer #(.PP_CYC(20), .SE_CYC(20), .B32_CYC(20), .B64_CYC(20), .CE_CYC(20)) dut_u (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io),
        .dout_o(dout), .dout_oe_o(dout_oe), .quad_enable_bit_i(quad_en), .protect_complement_i(prot_inv),
        .sector_granularity_select_i(prot_4k), .top_bottom_select_i(prot_low), .protect_range_i(bp),
        .block_lock_i(lock), .busy_o(busy), .write_enable_latch_o(wlat), .arr_we_o(arr_we),
        .arr_addr_o(arr_addr), .arr_wdata_o(arr_wdata), .erase_go_o(erase_go),
        .erase_kind_o(erase_kind), .erase_addr_o(erase_addr));
    // ******
    // Array side monitor
    // ******
    // Sampled mid-cycle, away from the edge that launches the strobes
    always @(negedge clk_sys_i) begin
        if (arr_we === 1'b1) act_mem[int'(arr_addr)] = arr_wdata;
        if (erase_go === 1'b1) begin
            n_er++;
            er_kind = erase_kind;
            er_addr = erase_addr;
        end
    end
    // ******
    // Checks and host sequences
    // ******
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : chk
    task automatic chk_page(input logic [7:0] exp_mem [int]);
        chk("writes", 24'(exp_mem.num()), 24'(act_mem.num()));
        foreach (exp_mem[a]) chk("byte", {16'h0, exp_mem[a]}, act_mem.exists(a) ? {16'h0, act_mem[a]} : 24'hXXXXXX);
    endtask : chk_page
    task automatic cfg(input logic q, input logic c, input logic s, input logic t, input logic [2:0] b,
                       input logic [63:0] l);
        @(posedge clk_sys_i);
        #1;
        {quad_en, prot_inv, prot_4k, prot_low, bp, lock} = {q, c, s, t, b, l};
    endtask : cfg
    task automatic wren();
        logic [7:0] dq [$];
        host_u.frame(OP_WREN, 0, 24'h0, dq, 1'b0, 0);
        chk("latch", 24'h1, {23'h0, wlat});
    endtask : wren
    task automatic wrdi();
        logic [7:0] dq [$];
        host_u.frame(OP_WRDI, 0, 24'h0, dq, 1'b0, 0);
        chk("latch", 24'h0, {23'h0, wlat});
    endtask : wrdi
    // Two status bytes; the first may be stale, so only the second counts
    task automatic status_read(input logic [7:0] exp);
        logic [7:0] dq [$];
        dq = '{8'h00, 8'h00};
        host_u.frame(OP_RDSR, 0, 24'h0, dq, 1'b0, 0);
        chk("status", {16'h0, exp}, {16'h0, host_u.rd_bits[7:0]});
        chk("dout_oe", 24'h1, {23'h0, host_u.oe_last});
        chk("dout_oe_idle", 24'h0, {23'h0, dout_oe});
    endtask : status_read
    task automatic run_op(input logic [7:0] opc, input int nadr, input logic [23:0] a, input int nd,
                          input bit quad, input int extra, input bit ok);
        logic [7:0] dq [$];
        logic [7:0] exp_mem [int];
        logic wlat0;
        int er0, t;
        wlat0 = wlat;
        er0 = n_er;
        act_mem.delete();
        for (int k = 0; k < nd; k++) begin
            dq.push_back(8'($urandom));
            exp_mem[int'({a[23:8], 8'(a[7:0] + 8'(k))})] = dq[k];
        end
        if (!ok) exp_mem.delete();
        host_u.frame(opc, nadr, a, dq, quad, extra);
        chk("busy", {23'h0, ok}, {23'h0, busy});
        if (ok && nd > 0) status_read(8'h03);
        t = 0;
        while (busy !== 1'b0 && t < 3000) begin
            @(posedge clk_sys_i);
            #1;
            t++;
        end
        if (t == 3000) begin
            fails++;
            complete_run();
        end
        chk("latch", {23'h0, ok ? 1'b0 : wlat0}, {23'h0, wlat});
        chk("erases", 24'(er0 + ((ok && nd == 0) ? 1 : 0)), 24'(n_er));
        chk_page(exp_mem);
    endtask : run_op
    initial begin
        void'($urandom(32'hAE12));
        repeat (5) @(posedge clk_sys_i);
        #1;
        resetn_i = 1'b1;
        chk("idle", 24'h0, {20'h0, busy, wlat, arr_we, erase_go});
        repeat (3) @(posedge clk_sys_i);
        run_op(OP_PROG, 3, 24'h000010, 4, 1'b0, 0, 1'b0);
        wren();
        run_op(OP_PROG, 3, 24'h0123F0, 20, 1'b0, 0, 1'b1);
        status_read(8'h00);
        wren();
        run_op(OP_PROG, 3, 24'h004500, 260, 1'b0, 0, 1'b1);
        wren();
        run_op(OP_PROG, 3, 24'h000200, 2, 1'b0, 3, 1'b0);
        run_op(OP_QPROG, 3, 24'h000300, 5, 1'b1, 0, 1'b0);
        cfg(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 64'h0);
        run_op(OP_QPROG, 3, 24'h0300FE, 6, 1'b1, 0, 1'b1);
        for (int i = 0; i < 5; i++) begin
            wren();
            adr = 24'($urandom) & MEM_TOP;
            run_op(E_OP[i], (i < 3) ? 3 : 0, adr, 0, 1'b0, 0, 1'b1);
            chk("kind", {22'h0, E_KIND[i]}, {22'h0, er_kind});
            chk("base", adr & ~E_SPAN[i], er_addr);
        end
        wren();
        run_op(OP_SE, 3, 24'h002000, 1, 1'b0, 0, 1'b0);
        run_op(OP_BE32, 2, 24'h002000, 0, 1'b0, 0, 1'b0);
        cfg(1'b1, 1'b0, 1'b0, 1'b0, 3'h7, 64'h0);
        run_op(OP_PROG, 3, 24'h200000, 3, 1'b0, 0, 1'b0);
        run_op(OP_CE1, 0, 24'h0, 0, 1'b0, 0, 1'b0);
        cfg(1'b1, 1'b0, 1'b1, 1'b1, 3'h1, 64'h0);
        run_op(OP_SE, 3, 24'h000800, 0, 1'b0, 0, 1'b0);
        run_op(OP_SE, 3, 24'h001800, 0, 1'b0, 0, 1'b1);
        wren();
        cfg(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 64'h20);
        run_op(OP_BE64, 3, 24'h05ABCD, 0, 1'b0, 0, 1'b0);
        run_op(OP_CE2, 0, 24'h0, 0, 1'b0, 0, 1'b0);
        wrdi();
        run_op(OP_SE, 3, 24'h001800, 0, 1'b0, 0, 1'b0);
        cfg(1'b1, 1'b1, 1'b0, 1'b0, 3'h1, 64'h0);
        wren();
        run_op(OP_SE, 3, 24'h001000, 0, 1'b0, 0, 1'b0);
        run_op(OP_SE, 3, 24'h3F1000, 0, 1'b0, 0, 1'b1);
        complete_run();
    end
endmodule : flash_program_erase_sequencer_tb_top
`default_nettype wire

// *** sim/fps_host_model.sv ***
// Host side of the serial flash link: drives chip select, link clock and lanes.
// Assumes the bench calls one task at a time; the link clock stands still between frames.
`timescale 1ns/100ps
`default_nettype none
module fps_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic [3:0] io_o,
    input wire logic dout_i,
    input wire logic dout_oe_i
);
    logic [15:0] rd_bits;
    logic oe_last;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        io_o = 4'hA;
    end
    // One 6 ns link clock period; lanes change only while the clock is low
    task automatic tick(input logic [3:0] v);
        io_o = v;
        #3;
        rd_bits = {rd_bits[14:0], dout_i};
        oe_last = dout_oe_i;
        sclk_o = 1'b1;
        #3;
        sclk_o = 1'b0;
    endtask : tick
    task automatic frame(input logic [7:0] opc, input int nadr, input logic [23:0] adr,
                         input logic [7:0] dat [$], input bit quad, input int extra);
        logic [31:0] hdr;
        hdr = {opc, adr};
        cs_n_o = 1'b0;
        #3;
        for (int i = 0; i < 8 + 8 * nadr; i++) tick({3'h0, hdr[31 - i]});
        foreach (dat[k]) begin
            if (quad) begin
                tick(dat[k][7:4]);
                tick(dat[k][3:0]);
            end else begin
                for (int b = 7; b >= 0; b--) tick({3'h0, dat[k][b]});
            end
        end
        for (int i = 0; i < extra; i++) tick(4'h0);
        #3;
        cs_n_o = 1'b1;
        // Released lanes must not keep the last value
        io_o = ~io_o;
        #100;
    endtask : frame
endmodule : fps_host_model
`default_nettype wire
